// ### rtl/fsms_top.sv
// Flash status and mat select logic with its register slave
// Behaviour
// - Failed erase sets erase error bit 5
// - Non-blank blank check sets bit 5
// - Clear status command clears both error flags
// - Bit 4 shows erase suspended state
// - Bit 3 shows program error outcome
// - Bit 2 reads zero, writes ignored
// - Bit 1 low while data flash busy
// - Bit 0 low while flash busy
// - Main ready bit resets to one
// - Code aa selects boot mat, else user
// - Mat changes directly on register write
// - User program mode never programs boot mat
// - Odd mat bits reset high in user boot mode
// - Command enable clears when flash becomes ready
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
module fsms_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// AXI4-Lite write channels
	input wire logic [fsms_pkg::FSMS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fsms_pkg::FSMS_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [fsms_pkg::FSMS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [fsms_pkg::FSMS_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Mode pins and command decoder
	input wire fsms_pkg::fsms_mode_t op_mode,
	input wire logic clear_status_cmd,
	input wire logic op_req,
	input wire fsms_pkg::fsms_op_t op_kind,
	input wire logic op_data_area,
	input wire logic suspend_req,
	input wire logic resume_req,
	// Flash array
	input wire logic array_done,
	input wire logic array_fail,
	output logic array_start,
	output fsms_pkg::fsms_op_t array_kind,
	output logic array_data_area,
	output logic array_boot_mat,
	output logic array_hold,
	// Status
	output logic boot_mat_selected,
	output logic software_command_enable,
	output logic irq
);
	import fsms_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	fsms_state_t state; // Sequencer state
	fsms_state_t next_state; // Its next value
	logic flash_ready; // Main flash ready
	logic data_area_ready; // Data flash ready
	logic erase_error_flag; // Erase or blank check error
	logic program_error_flag; // Program error
	logic [7:0] mat_select; // Mat select register
	logic cmd_en_armed; // A zero was written to the enable
	logic [FSMS_IRQ_W-1:0] irq_status; // Sticky events
	logic [FSMS_IRQ_W-1:0] irq_mask; // Interrupt enables
	logic [FSMS_IRQ_W-1:0] next_irq_status; // Next sticky events
	logic [FSMS_IRQ_W-1:0] next_irq_mask; // Next enables
	logic [7:0] next_mat_select; // Next mat select
	logic wr_fire; // Register write this edge
	logic [FSMS_ADDR_W-1:0] wr_addr; // Write offset
	logic [FSMS_DATA_W-1:0] wr_data; // Write data
	logic [3:0] wr_strb; // Write byte strobes
	logic [FSMS_ADDR_W-1:0] rd_addr; // Read offset
	wire [7:0] status_byte; // Assembled flash_status
	wire [FSMS_DATA_W-1:0] rd_data; // Read mux output
	wire rd_hit; // Read address mapped
	wire wr_hit; // Write address mapped

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	fsms_axil u_axil (
		.core_clk(core_clk),
		.srst(srst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_fire(wr_fire),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_hit(wr_hit),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Registers are at most eight bits wide, only lane 0 carries them
	wire wr_lane0 = wr_fire & wr_strb[0];
	wire wr_mat = wr_lane0 & (wr_addr == FSMS_OFS_MAT_SELECT);
	wire wr_ctrl = wr_lane0 & (wr_addr == FSMS_OFS_CMD_CTRL);
	wire wr_istat = wr_lane0 & (wr_addr == FSMS_OFS_IRQ_STATUS);
	wire wr_imask = wr_lane0 & (wr_addr == FSMS_OFS_IRQ_MASK);
	// Status accepts writes but ignores them
	assign wr_hit = (wr_addr == FSMS_OFS_STATUS) | (wr_addr == FSMS_OFS_MAT_SELECT)
		| (wr_addr == FSMS_OFS_CMD_CTRL) | (wr_addr == FSMS_OFS_IRQ_STATUS)
		| (wr_addr == FSMS_OFS_IRQ_MASK);
	wire rd_status = rd_addr == FSMS_OFS_STATUS;
	wire rd_mat = rd_addr == FSMS_OFS_MAT_SELECT;
	wire rd_ctrl = rd_addr == FSMS_OFS_CMD_CTRL;
	wire rd_istat = rd_addr == FSMS_OFS_IRQ_STATUS;
	wire rd_imask = rd_addr == FSMS_OFS_IRQ_MASK;
	assign rd_hit = rd_status | rd_mat | rd_ctrl | rd_istat | rd_imask;

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Bits 7, 6 and 2 are tied low; writes never reach them
	assign status_byte = {2'h0, erase_error_flag, state == FSMS_SUSPEND,
		program_error_flag, 1'b0, data_area_ready, flash_ready};
	assign rd_data = rd_status ? {24'h0, status_byte}
		: rd_mat ? {24'h0, mat_select}
		: rd_ctrl ? {31'h0, software_command_enable}
		: rd_istat ? {29'h0, irq_status}
		: rd_imask ? {29'h0, irq_mask}
		: 32'h0;

	// ------------------------------------------------------------
	// Request qualification
	// ------------------------------------------------------------
	// Boot mat programming is barred in user program mode
	wire boot_refused = (op_mode == FSMS_MODE_USER_PROGRAM) && boot_mat_selected
		&& (op_kind == FSMS_OP_PROGRAM) && !op_data_area;
	wire mode_ok = op_mode != FSMS_MODE_USER;
	wire op_accept = op_req && (state == FSMS_IDLE) && software_command_enable
		&& mode_ok && !boot_refused;
	wire op_reject = op_req && !op_accept;
	wire busy = (state == FSMS_MAIN_BUSY) || (state == FSMS_DATA_BUSY);
	// Completion only counts while an operation runs
	wire op_finish = array_done && busy;
	wire go_suspend = suspend_req && busy && (array_kind == FSMS_OP_ERASE);
	wire go_resume = resume_req && (state == FSMS_SUSPEND);
	// Error sources split by operation kind
	wire set_erase_err = op_finish && array_fail && (array_kind != FSMS_OP_PROGRAM);
	wire set_prog_err = op_finish && array_fail && (array_kind == FSMS_OP_PROGRAM);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Done wins over a suspend request in the same cycle
	always_comb begin
		next_state = state;
		unique case (state)
			FSMS_IDLE: begin
				if (op_accept) begin
					next_state = op_data_area ? FSMS_DATA_BUSY : FSMS_MAIN_BUSY;
				end
			end
			FSMS_MAIN_BUSY, FSMS_DATA_BUSY: begin
				if (op_finish) begin
					next_state = FSMS_IDLE;
				end else if (go_suspend) begin
					next_state = FSMS_SUSPEND;
				end
			end
			FSMS_SUSPEND: begin
				if (go_resume) begin
					next_state = array_data_area ? FSMS_DATA_BUSY : FSMS_MAIN_BUSY;
				end
			end
		endcase
	end

	// Ready levels follow the next state
	wire next_busy = (next_state == FSMS_MAIN_BUSY) || (next_state == FSMS_DATA_BUSY);
	wire next_ready = !next_busy;
	wire next_data_ready = next_state != FSMS_DATA_BUSY;
	wire ready_rise = next_ready && !flash_ready;

	// ------------------------------------------------------------
	// Sequencer and ready flags
	// ------------------------------------------------------------
	// Nothing runs at reset, so both ready bits start high
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= FSMS_IDLE;
			flash_ready <= 1'b1;
			data_area_ready <= 1'b1;
		end else begin
			state <= next_state;
			flash_ready <= next_ready;
			data_area_ready <= next_data_ready;
		end
	end

	// ------------------------------------------------------------
	// Error flags
	// ------------------------------------------------------------
	// A new error beats a clear status in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			erase_error_flag <= 1'b0;
			program_error_flag <= 1'b0;
		end else begin
			if (set_erase_err) begin
				erase_error_flag <= 1'b1;
			end else if (clear_status_cmd) begin
				erase_error_flag <= 1'b0;
			end
			if (set_prog_err) begin
				program_error_flag <= 1'b1;
			end else if (clear_status_cmd) begin
				program_error_flag <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Mat select
	// ------------------------------------------------------------
	// Written value takes effect at once on the mat choice
	assign next_mat_select = wr_mat ? wr_data[7:0] : mat_select;

	// Reset value depends on the mode pins, sampled synchronously
	always_ff @(posedge core_clk) begin
		if (srst) begin
			if (op_mode == FSMS_MODE_USER_BOOT) begin
				mat_select <= FSMS_MAT_RST_BOOT;
				boot_mat_selected <= 1'b1;
			end else begin
				mat_select <= FSMS_MAT_RST_OTHER;
				boot_mat_selected <= 1'b0;
			end
		end else begin
			mat_select <= next_mat_select;
			boot_mat_selected <= next_mat_select == FSMS_BOOT_MAT_CODE;
		end
	end

	// ------------------------------------------------------------
	// Command enable
	// ------------------------------------------------------------
	// Setting needs a zero written first; ready rise clears it
	always_ff @(posedge core_clk) begin
		if (srst) begin
			software_command_enable <= 1'b0;
			cmd_en_armed <= 1'b0;
		end else if (ready_rise) begin
			software_command_enable <= 1'b0;
			cmd_en_armed <= 1'b0;
		end else if (wr_ctrl) begin
			if (!wr_data[FSMS_CTRL_CMD_EN]) begin
				software_command_enable <= 1'b0;
				cmd_en_armed <= 1'b1;
			end else if (cmd_en_armed) begin
				software_command_enable <= 1'b1;
				cmd_en_armed <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Array control
	// ------------------------------------------------------------
	// Operation parameters latched at acceptance
	always_ff @(posedge core_clk) begin
		if (srst) begin
			array_start <= 1'b0;
			array_kind <= FSMS_OP_ERASE;
			array_data_area <= 1'b0;
			array_boot_mat <= 1'b0;
			array_hold <= 1'b0;
		end else begin
			array_start <= op_accept;
			array_hold <= next_state == FSMS_SUSPEND;
			if (op_accept) begin
				array_kind <= op_kind;
				array_data_area <= op_data_area;
				array_boot_mat <= boot_mat_selected && !op_data_area;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	wire [FSMS_IRQ_W-1:0] irq_event = {op_reject, set_erase_err | set_prog_err, op_finish};
	wire [FSMS_IRQ_W-1:0] irq_clear = wr_istat ? wr_data[FSMS_IRQ_W-1:0] : FSMS_IRQ_RST;
	// Events beat a write-one clear in the same cycle
	assign next_irq_status = (irq_status & ~irq_clear) | irq_event;
	assign next_irq_mask = wr_imask ? wr_data[FSMS_IRQ_W-1:0] : irq_mask;

	// Level output follows unmasked sticky bits
	always_ff @(posedge core_clk) begin
		if (srst) begin
			irq_status <= FSMS_IRQ_RST;
			irq_mask <= FSMS_IRQ_RST;
			irq <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			irq <= |(next_irq_status & next_irq_mask);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_erase_err_set: assert property (@(posedge core_clk) disable iff (srst)
		(op_finish && array_fail && array_kind == FSMS_OP_ERASE) |=> status_byte[5])
		else $error("erase failure did not set error flag");
	a_blank_err_set: assert property (@(posedge core_clk) disable iff (srst)
		(op_finish && array_fail && array_kind == FSMS_OP_BLANK) |=> erase_error_flag)
		else $error("blank check failure did not set error flag");
	a_clear_status: assert property (@(posedge core_clk) disable iff (srst)
		(clear_status_cmd && !op_finish) |=> !erase_error_flag && !program_error_flag)
		else $error("clear status left an error flag set");
	a_suspend_bit: assert property (@(posedge core_clk) disable iff (srst)
		(go_suspend && !op_finish) |=> status_byte[4] && array_hold && flash_ready)
		else $error("suspend not shown in status");
	a_prog_err_set: assert property (@(posedge core_clk) disable iff (srst)
		(op_finish && array_fail && array_kind == FSMS_OP_PROGRAM)
		|=> status_byte[3] && !$changed(erase_error_flag))
		else $error("program failure not reported on bit 3");
	a_bit2_zero: assert property (@(posedge core_clk) disable iff (srst)
		wr_fire && wr_addr == FSMS_OFS_STATUS |=> !status_byte[2] && !status_byte[7])
		else $error("status reserved bit changed");
	a_data_busy: assert property (@(posedge core_clk) disable iff (srst)
		(op_accept && op_data_area) |=> !data_area_ready && !flash_ready && array_start)
		else $error("data flash busy not shown");
	a_main_busy: assert property (@(posedge core_clk) disable iff (srst)
		(op_accept && !op_data_area) |=> !flash_ready && data_area_ready)
		else $error("main flash busy not shown");
	a_done_ready: assert property (@(posedge core_clk) disable iff (srst)
		op_finish |=> flash_ready && data_area_ready && state == FSMS_IDLE)
		else $error("ready not restored after completion");
	a_ready_reset: assert property (@(posedge core_clk)
		!srst && $past(srst) |-> flash_ready && !status_byte[5] && !status_byte[3])
		else $error("status wrong after reset");
	a_boot_code: assert property (@(posedge core_clk) disable iff (srst)
		wr_mat |=> boot_mat_selected == ($past(wr_data[7:0]) == FSMS_BOOT_MAT_CODE))
		else $error("mat choice does not follow written code");
	a_boot_refuse: assert property (@(posedge core_clk) disable iff (srst)
		(op_req && boot_refused) |=> !array_start ##1 irq_status[FSMS_IRQ_REFUSED])
		else $error("boot mat programmed in user program mode");
	a_mat_reset: assert property (@(posedge core_clk)
		!srst && $past(srst) |-> mat_select == (($past(op_mode) == FSMS_MODE_USER_BOOT)
		? FSMS_MAT_RST_BOOT : FSMS_MAT_RST_OTHER))
		else $error("mat select reset value wrong");
	a_cmd_en_clear: assert property (@(posedge core_clk) disable iff (srst)
		$rose(flash_ready) |-> !software_command_enable)
		else $error("command enable not cleared on ready");
	a_err_sticky: assert property (@(posedge core_clk) disable iff (srst)
		(erase_error_flag && !clear_status_cmd) |=> erase_error_flag)
		else $error("erase error flag dropped without clear");

endmodule // fsms_top

// ### include/fsms_pkg.sv
// Shared constants and types of the flash status and mat select block
package fsms_pkg;

	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int FSMS_ADDR_W = 8; // Byte address width of the slave
	localparam int FSMS_DATA_W = 32; // AXI4-Lite data width
	localparam logic [1:0] FSMS_RESP_OKAY = 2'h0; // Normal answer
	localparam logic [1:0] FSMS_RESP_SLVERR = 2'h2; // Unmapped address

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] FSMS_OFS_STATUS = 8'h00; // flash_status, read only
	localparam logic [7:0] FSMS_OFS_MAT_SELECT = 8'h04; // mat_select
	localparam logic [7:0] FSMS_OFS_CMD_CTRL = 8'h08; // Command enable control
	localparam logic [7:0] FSMS_OFS_IRQ_STATUS = 8'h0c; // Sticky events, write one to clear
	localparam logic [7:0] FSMS_OFS_IRQ_MASK = 8'h10; // Interrupt enables

	// ------------------------------------------------------------
	// Field positions of flash_status
	// ------------------------------------------------------------
	localparam int FSMS_ST_FLASH_READY = 0; // Main flash ready
	localparam int FSMS_ST_DATA_READY = 1; // Data flash ready
	localparam int FSMS_ST_PROG_ERR = 3; // Program error
	localparam int FSMS_ST_SUSPEND = 4; // Erase suspended
	localparam int FSMS_ST_ERASE_ERR = 5; // Erase or blank check error

	// ------------------------------------------------------------
	// Other fields and values
	// ------------------------------------------------------------
	localparam int FSMS_CTRL_CMD_EN = 0; // software_command_enable bit
	localparam int FSMS_IRQ_W = 3; // Number of interrupt events
	localparam int FSMS_IRQ_DONE = 0; // Operation finished
	localparam int FSMS_IRQ_ERROR = 1; // Operation ended with an error
	localparam int FSMS_IRQ_REFUSED = 2; // Request refused
	localparam logic [7:0] FSMS_BOOT_MAT_CODE = 8'haa; // Selects the user boot mat
	localparam logic [7:0] FSMS_MAT_RST_BOOT = 8'haa; // Odd bits set, user boot mode
	localparam logic [7:0] FSMS_MAT_RST_OTHER = 8'h00; // Reset value, other modes
	localparam logic [2:0] FSMS_IRQ_RST = 3'h0; // Reset of status and mask

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		FSMS_OP_ERASE,
		FSMS_OP_BLANK,
		FSMS_OP_PROGRAM
	} fsms_op_t; // Array operation kinds

	typedef enum logic [2:0] {
		FSMS_MODE_USER,
		FSMS_MODE_USER_PROGRAM,
		FSMS_MODE_USER_BOOT,
		FSMS_MODE_BOOT,
		FSMS_MODE_PROGRAMMER
	} fsms_mode_t; // Operating modes from the mode pins

	typedef enum logic [1:0] {
		FSMS_IDLE,
		FSMS_MAIN_BUSY,
		FSMS_DATA_BUSY,
		FSMS_SUSPEND
	} fsms_state_t; // Sequencer states

endpackage

// ### rtl/fsms_axil.sv
// AXI4-Lite slave front end of the flash status block
`timescale 1ns/1ns
module fsms_axil (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Write address and data channels
	input wire logic [fsms_pkg::FSMS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [fsms_pkg::FSMS_DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// Write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// Read channels
	input wire logic [fsms_pkg::FSMS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [fsms_pkg::FSMS_DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register side
	output logic wr_fire,
	output logic [fsms_pkg::FSMS_ADDR_W-1:0] wr_addr,
	output logic [fsms_pkg::FSMS_DATA_W-1:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_hit,
	output logic [fsms_pkg::FSMS_ADDR_W-1:0] rd_addr,
	input wire logic [fsms_pkg::FSMS_DATA_W-1:0] rd_data,
	input wire logic rd_hit
);
	import fsms_pkg::*;

	logic have_aw; // Write address held
	logic have_w; // Write data held

	// Both halves held and no response pending
	assign wr_fire = have_aw & have_w & ~s_axi_bvalid;
	// Read decode looks straight at the offered address
	assign rd_addr = s_axi_araddr;

	// ------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------
	// Address and data are taken independently, response after both
	always_ff @(posedge core_clk) begin
		if (srst) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= FSMS_RESP_OKAY;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= s_axi_awaddr;
				have_aw <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				have_w <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				// Register write happens on this edge
				have_aw <= 1'b0;
				have_w <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? FSMS_RESP_OKAY : FSMS_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				// Reopen both channels once answered
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Data captured at the address handshake, answered next cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= FSMS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_hit ? FSMS_RESP_OKAY : FSMS_RESP_SLVERR;
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

endmodule // fsms_axil

// ### verification/fsms_array_model.sv
// Behavioural flash array that answers start pulses
`timescale 1ns/1ns
module fsms_array_model (
	// Clock and array handshake
	input wire logic core_clk,
	input wire logic array_start,
	input wire logic array_hold,
	// Outcome and latency chosen by the bench
	input wire logic fail_in,
	input wire logic [3:0] lat,
	output logic array_done = 1'h0,
	output logic array_fail = 1'h0
);
	int cnt = -1; // Cycles left, idle at -1
	// Count down unless held; fail toggles outside done
	always @(posedge core_clk) begin
		array_done <= 1'h0;
		array_fail <= ~array_fail;
		if (array_start) begin
			cnt <= lat;
		end else if (cnt == 0) begin
			array_done <= 1'h1;
			array_fail <= fail_in;
			cnt <= -1;
		end else if (cnt > 0 && !array_hold) begin
			cnt <= cnt - 1;
		end
	end
endmodule // fsms_array_model

// ### verification/tb_top.sv
// Self-checking bench of the flash status block
`timescale 1ns/1ns
module tb_top;
	import fsms_pkg::*;
	logic core_clk = 0, srst = 1, awv = 0, wv = 0, bvr = 0, arv = 0, rr = 0;
	logic [7:0] aw = 0, ar = 0;
	logic [31:0] wd = 0, rdat, rv;
	logic awr, wrd, bv, arr, rvl, start, hold, boot, cen, irq, done, afail, adat, abm;
	logic [1:0] br, rrsp, rs;
	fsms_mode_t md = FSMS_MODE_USER_BOOT;
	fsms_op_t kd = FSMS_OP_ERASE;
	fsms_op_t ak;
	logic clr = 0, req = 0, da = 0, sus = 0, res = 0, fl = 0;
	logic [3:0] lat = 4'h4;
	int err_total = 0, tests_run = 0;
	always #5 core_clk = ~core_clk;
	fsms_top i_dut (.core_clk(core_clk), .srst(srst), .s_axi_awaddr(aw),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(bvr), .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rvl), .s_axi_rready(rr),
		.op_mode(md), .clear_status_cmd(clr), .op_req(req), .op_kind(kd),
		.op_data_area(da), .suspend_req(sus), .resume_req(res), .array_done(done),
		.array_fail(afail), .array_start(start), .array_kind(ak), .array_data_area(adat),
		.array_boot_mat(abm), .array_hold(hold), .boot_mat_selected(boot),
		.software_command_enable(cen), .irq(irq));
	fsms_array_model i_arr (.core_clk(core_clk), .array_start(start), .array_hold(hold),
		.fail_in(fl), .lat(lat), .array_done(done), .array_fail(afail));
	function automatic logic [7:0] err_bit(fsms_op_t k);
		return (k == FSMS_OP_PROGRAM) ? 8'h08 : 8'h20;
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge core_clk);
		aw <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bvr <= 1'h1;
		do begin
			@(posedge core_clk);
			if (awr) awv <= 1'h0;
			if (wrd) wv <= 1'h0;
		end while (!bv);
		bvr <= 1'h0;
	endtask
	task automatic rd(logic [7:0] a);
		@(posedge core_clk);
		ar <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do begin
			@(posedge core_clk);
			if (arr) arv <= 1'h0;
		end while (!rvl);
		rv = rdat;
		rs = rrsp;
		rr <= 1'h0;
	endtask
	task automatic st(logic [7:0] e);
		rd(FSMS_OFS_STATUS);
		chk("status", {24'h0, e}, rv);
	endtask
	task automatic run(fsms_op_t k, logic a, logic f);
		wr(FSMS_OFS_CMD_CTRL, 32'h0);
		wr(FSMS_OFS_CMD_CTRL, 32'h1);
		lat <= 4'($urandom_range(12, 4));
		kd <= k;
		da <= a;
		fl <= f;
		req <= 1'h1;
		@(posedge core_clk);
		req <= 1'h0;
	endtask
	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hdd4e));
		repeat (12) @(posedge core_clk);
		srst <= 1'h0;
		md <= FSMS_MODE_USER_PROGRAM;
		st(8'h03);
		rd(FSMS_OFS_MAT_SELECT);
		chk("mat", 32'haa, rv);
		wr(FSMS_OFS_STATUS, 32'h3c);
		chk("bresp", {30'h0, FSMS_RESP_OKAY}, {30'h0, br});
		st(8'h03);
		rd(8'h40);
		chk("rresp", {30'h0, FSMS_RESP_SLVERR}, {30'h0, rs});
		wr(8'h40, 32'h0);
		chk("bresp", {30'h0, FSMS_RESP_SLVERR}, {30'h0, br});
		$display("Test reset done");
		// Random codes first, boot code last so the boot mat stays chosen
		for (int i = 0; i < 6; i++) begin
			logic [7:0] m;
			m = (i == 5) ? 8'haa : 8'($urandom);
			wr(FSMS_OFS_MAT_SELECT, {24'h0, m});
			chk("boot", {31'h0, m == 8'haa}, {31'h0, boot});
		end
		run(FSMS_OP_PROGRAM, 1'h0, 1'h0);
		st(8'h03);
		rd(FSMS_OFS_IRQ_STATUS);
		chk("refused", 32'h4, rv);
		chk("irq", 32'h0, {31'h0, irq});
		wr(FSMS_OFS_IRQ_MASK, 32'h7);
		chk("irq", 32'h1, {31'h0, irq});
		wr(FSMS_OFS_IRQ_STATUS, 32'h7);
		chk("irq", 32'h0, {31'h0, irq});
		// Erasing the boot mat stays allowed in user program mode
		run(FSMS_OP_ERASE, 1'h0, 1'h0);
		@(posedge core_clk iff done);
		chk("boot_mat", 32'h1, {31'h0, abm});
		wr(FSMS_OFS_MAT_SELECT, 32'h0);
		$display("Test mat done");
		for (int i = 0; i < 3; i++) begin
			run(fsms_op_t'(i), i == 1, 1'h1);
			st((i == 1) ? 8'h00 : 8'h02);
			chk("kind", i, {30'h0, ak});
			chk("area", {31'h0, i == 1}, {31'h0, adat});
			chk("boot_mat", 32'h0, {31'h0, abm});
			@(posedge core_clk iff done);
			st(8'h03 | err_bit(fsms_op_t'(i)));
			chk("cmd_en", 32'h0, {31'h0, cen});
			chk("irq", 32'h1, {31'h0, irq});
			wr(FSMS_OFS_IRQ_STATUS, 32'h3);
			run(fsms_op_t'(i), 1'h0, 1'h0);
			@(posedge core_clk iff done);
			st(8'h03 | err_bit(fsms_op_t'(i)));
			clr <= 1'h1;
			@(posedge core_clk);
			clr <= 1'h0;
			st(8'h03);
		end
		$display("Test operations done");
		run(FSMS_OP_ERASE, 1'h0, 1'h0);
		sus <= 1'h1;
		@(posedge core_clk);
		sus <= 1'h0;
		st(8'h13);
		res <= 1'h1;
		@(posedge core_clk);
		res <= 1'h0;
		@(posedge core_clk iff done);
		st(8'h03);
		$display("Test suspend done");
		print_verdict;
	end
	// Tests need a few hundred cycles; cut a hang at 20000 cycles
	initial begin
		#200000;
		err_total++;
		print_verdict;
	end
endmodule // tb_top
